// [rtl/mst_regs.svh]
// register offsets, field positions and constants of the transfer engine
`ifndef MST_REGS_SVH
`define MST_REGS_SVH
`define MST_OFS_CTRL 4'h0
`define MST_OFS_CHPTR 4'h1
`define MST_OFS_STATUS 4'h2
`define MST_OFS_MASK 4'h3
`define MST_OFS_MODE 4'h4
`define MST_OFS_STATE 4'h5
`define MST_CTRL_HIGH_MAP 0
`define MST_MODE_VEC_BIT 7
`define MST_MODE_HI_BIT 6
`define MST_MODE_MID_BIT 5
`define MST_MODE_LO_BIT 4
`define MST_ST_DONE_BIT 0
`define MST_ST_END_BIT 1
`define MST_ST_VEC_BIT 2
`define MST_LOW_MAP_BASE 20'h0fe00
`define MST_HIGH_MAP_BASE 20'hffe00
`define MST_RESET_CTRL 8'h00
`define MST_RESET_MASK 8'h00
`define MST_RESET_CHPTR 8'h00
`define MST_TYPE_C_CODE 2'h3
`define MST_OFS_COUNT 8'h00
`define MST_OFS_PREG 8'h01
`define MST_OFS_MODEB 8'h01
`endif

// [rtl/mst_pkg.sv]
// types of the transfer engine
package mst_pkg;
    typedef enum logic [2:0] {
        MST_IDLE = 3'b000,
        MST_RD_MODE = 3'b001,
        MST_RD_CNT = 3'b011,
        MST_RD_PREG = 3'b010,
        MST_MOVE_RD = 3'b110,
        MST_MOVE_WR = 3'b111,
        MST_WR_CNT = 3'b101,
        MST_DONE = 3'b100
    } mst_state_t;
    typedef enum logic [1:0] {
        MST_PTR_DEC_KEEP = 2'h0,
        MST_PTR_DEC_BOTH = 2'h1,
        MST_PTR_INC_KEEP = 2'h2,
        MST_PTR_INC_BOTH = 2'h3
    } mst_ptr_upd_t;
endpackage

// [rtl/mst_engine.sv]
// type A transfer engine with mode byte decode and avalon register slave
//
// Operation
// - at count zero, mode bit 7 low raises an interrupt, high instead marks the next request vectored.
// - for type C the upper mode bit picks 1 or 2 byte timer data, middle enables addition, low ring.
// - channels live in a 256-byte window at fe00 for low map or ffe00 for high map.
// - the channel pointer is the low byte of the highest channel address, upper bits fixed.
// - each type A service moves data between channel buffer and a peripheral register.
// - one 8 or 16 bit transfer per request, repeating until the count is used up.
// - the type A count is an 8-bit counter in the channel, locating the buffer with the pointer.
// - an 8-bit register pointer in the channel gives the peripheral register's low address byte.
// - one-byte buffer address is channel pointer minus count minus 1.
// - two-byte buffer address is channel pointer minus twice the count minus 1.
// - software keeps the mode byte in ram just above the channel pointer and the engine fetches it there.
// - for types A and B, low mode bit is direction and upper mode bit is size.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "mst_regs.svh"
module mst_engine (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // avalon register slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // service request from interrupt controller
    input wire logic service_req,
    output logic service_ack,
    output logic end_irq_req,
    output logic vectored_next,
    // internal ram port, one cycle read latency
    output logic [19:0] ram_addr,
    output logic ram_rd,
    output logic ram_wr,
    output logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata,
    // peripheral register port, one cycle read latency
    output logic [7:0] periph_addr,
    output logic periph_rd,
    output logic periph_wr,
    output logic [7:0] periph_wdata,
    input wire logic [7:0] periph_rdata,
    // type C decode and interrupt
    output logic type_c_sel,
    output logic timer_size_two,
    output logic auto_add_en,
    output logic ring_en,
    output logic [1:0] ptr_update,
    output logic irq
);
    // buffer address from pointer and count
    function automatic logic [7:0] buf_low(input logic [7:0] chp, input logic [7:0] cnt,
                                          input logic two);
        logic [7:0] step;
        step = two ? {cnt[6:0], 1'b0} : cnt;
        buf_low = chp - step - 8'h01;
    endfunction

    mst_pkg::mst_state_t state, next_state;
    logic [7:0] ctrl, next_ctrl, chptr, next_chptr, mask, next_mask;
    logic [7:0] status, next_status, mode, next_mode, count, next_count;
    logic [7:0] preg, next_preg, data, next_data;
    logic byte_idx, next_byte_idx, vec_pend, next_vec_pend;
    logic [19:0] base;
    logic two, to_mem;

    // window base and mode field decode
    assign base = ctrl[`MST_CTRL_HIGH_MAP] ? `MST_HIGH_MAP_BASE : `MST_LOW_MAP_BASE;
    assign two = mode[`MST_MODE_HI_BIT];
    assign to_mem = mode[`MST_MODE_LO_BIT];
    assign type_c_sel = (mode[3:2] == `MST_TYPE_C_CODE);
    assign ptr_update = type_c_sel ? mode[1:0] : 2'h0;
    assign timer_size_two = type_c_sel & mode[`MST_MODE_HI_BIT];
    assign auto_add_en = type_c_sel & mode[`MST_MODE_MID_BIT];
    assign ring_en = type_c_sel & mode[`MST_MODE_LO_BIT];
    assign irq = |(status & mask);
    assign vectored_next = vec_pend;
    assign avs_waitrequest = 1'b0;

    // sequencing, bus ports and register writes
    always_comb begin
        next_state = state;
        next_ctrl = ctrl;
        next_chptr = chptr;
        next_mask = mask;
        next_status = status;
        next_mode = mode;
        next_count = count;
        next_preg = preg;
        next_data = data;
        next_byte_idx = byte_idx;
        next_vec_pend = vec_pend;
        ram_addr = 20'h00000;
        ram_rd = 1'b0;
        ram_wr = 1'b0;
        ram_wdata = data;
        periph_addr = preg;
        periph_rd = 1'b0;
        periph_wr = 1'b0;
        periph_wdata = data;
        service_ack = 1'b0;
        end_irq_req = 1'b0;
        case (state)
            mst_pkg::MST_IDLE: begin
                if (service_req) begin
                    // counter sits at the pointer, mode byte just above the channel
                    ram_addr = base | {12'h000, chptr + `MST_OFS_MODEB};
                    ram_rd = 1'b1;
                    next_state = mst_pkg::MST_RD_MODE;
                end
            end
            mst_pkg::MST_RD_MODE: begin
                next_mode = ram_rdata;
                ram_addr = base | {12'h000, chptr - `MST_OFS_COUNT};
                ram_rd = 1'b1;
                next_state = mst_pkg::MST_RD_CNT;
            end
            mst_pkg::MST_RD_CNT: begin
                next_count = ram_rdata;
                ram_addr = base | {12'h000, chptr - `MST_OFS_PREG};
                ram_rd = 1'b1;
                next_byte_idx = 1'b0;
                next_state = mst_pkg::MST_RD_PREG;
            end
            mst_pkg::MST_RD_PREG: begin
                next_preg = ram_rdata;
                if (type_c_sel || count == 8'h00) begin
                    next_state = mst_pkg::MST_DONE;
                end else begin
                    next_state = mst_pkg::MST_MOVE_RD;
                end
            end
            mst_pkg::MST_MOVE_RD: begin
                // source read, byte index selects the upper byte of a word
                if (to_mem) begin
                    periph_addr = preg + {7'h00, byte_idx};
                    periph_rd = 1'b1;
                end else begin
                    ram_addr = base | {12'h000, buf_low(chptr, count, two) - {7'h00, byte_idx}};
                    ram_rd = 1'b1;
                end
                next_state = mst_pkg::MST_MOVE_WR;
            end
            mst_pkg::MST_MOVE_WR: begin
                if (to_mem) begin
                    ram_addr = base | {12'h000, buf_low(chptr, count, two) - {7'h00, byte_idx}};
                    ram_wdata = periph_rdata;
                    ram_wr = 1'b1;
                    next_data = periph_rdata;
                end else begin
                    periph_addr = preg + {7'h00, byte_idx};
                    periph_wdata = ram_rdata;
                    periph_wr = 1'b1;
                    next_data = ram_rdata;
                end
                if (two && !byte_idx) begin
                    next_byte_idx = 1'b1;
                    next_state = mst_pkg::MST_MOVE_RD;
                end else begin
                    next_state = mst_pkg::MST_WR_CNT;
                end
            end
            mst_pkg::MST_WR_CNT: begin
                ram_addr = base | {12'h000, chptr - `MST_OFS_COUNT};
                ram_wdata = count - 8'h01;
                ram_wr = 1'b1;
                next_count = count - 8'h01;
                next_status[`MST_ST_DONE_BIT] = 1'b1;
                if (count == 8'h01) begin
                    if (mode[`MST_MODE_VEC_BIT]) begin
                        next_vec_pend = 1'b1;
                        next_status[`MST_ST_VEC_BIT] = 1'b1;
                    end else begin
                        end_irq_req = 1'b1;
                        next_status[`MST_ST_END_BIT] = 1'b1;
                    end
                end
                next_state = mst_pkg::MST_DONE;
            end
            mst_pkg::MST_DONE: begin
                service_ack = 1'b1;
                if (vec_pend && state == mst_pkg::MST_DONE && count != 8'h00) begin
                    next_vec_pend = 1'b1;
                end
                next_state = mst_pkg::MST_IDLE;
            end
            default: next_state = mst_pkg::MST_IDLE;
        endcase
        // a new request while vectored pending consumes the pending flag
        if (state == mst_pkg::MST_IDLE && service_req && vec_pend) begin
            next_vec_pend = 1'b0;
        end
        // register writes, status cleared by writing one, set wins unless the bit was already set
        if (avs_write && avs_byteenable[0]) begin
            case (avs_address)
                `MST_OFS_CTRL: next_ctrl = avs_writedata[7:0];
                `MST_OFS_CHPTR: next_chptr = avs_writedata[7:0];
                `MST_OFS_MASK: next_mask = avs_writedata[7:0];
                `MST_OFS_STATUS: next_status = (status & ~avs_writedata[7:0]) |
                                               (next_status & ~status);
                default: next_ctrl = next_ctrl;
            endcase
        end
    end

    // read data mux, unmapped reads zero
    always_comb begin
        avs_readdata = 32'h00000000;
        if (avs_read) begin
            case (avs_address)
                `MST_OFS_CTRL: avs_readdata = {24'h000000, ctrl};
                `MST_OFS_CHPTR: avs_readdata = {24'h000000, chptr};
                `MST_OFS_STATUS: avs_readdata = {24'h000000, status};
                `MST_OFS_MASK: avs_readdata = {24'h000000, mask};
                `MST_OFS_MODE: avs_readdata = {24'h000000, mode};
                `MST_OFS_STATE: avs_readdata = {16'h0000, count, 4'h0, vec_pend, state};
                default: avs_readdata = 32'h00000000;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= mst_pkg::MST_IDLE;
            ctrl <= `MST_RESET_CTRL;
            chptr <= `MST_RESET_CHPTR;
            mask <= `MST_RESET_MASK;
            status <= 8'h00;
            mode <= 8'h00;
            count <= 8'h00;
            preg <= 8'h00;
            data <= 8'h00;
            byte_idx <= 1'b0;
            vec_pend <= 1'b0;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            chptr <= next_chptr;
            mask <= next_mask;
            status <= next_status;
            mode <= next_mode;
            count <= next_count;
            preg <= next_preg;
            data <= next_data;
            byte_idx <= next_byte_idx;
            vec_pend <= next_vec_pend;
        end
    end

    // end of count outcome follows mode bit 7
    property p_end_irq;
        @(posedge clock) disable iff (reset)
        end_irq_req |-> !mode[7] && count == 8'h01;
    endproperty
    a_end_irq: assert property (p_end_irq) else $error("end irq with wrong mode or count");

    property p_count_dec;
        @(posedge clock) disable iff (reset)
        state == mst_pkg::MST_WR_CNT |=> count == $past(count) - 8'h01;
    endproperty
    a_count_dec: assert property (p_count_dec) else $error("count not decremented");

    property p_window;
        @(posedge clock) disable iff (reset)
        (ram_rd || ram_wr) |-> ram_addr[19:8] == base[19:8];
    endproperty
    a_window: assert property (p_window) else $error("ram access outside window");

    property p_one_byte_addr;
        @(posedge clock) disable iff (reset)
        (state == mst_pkg::MST_MOVE_RD && !to_mem && !two)
            |-> ram_addr[7:0] == chptr - count - 8'h01;
    endproperty
    a_one_byte_addr: assert property (p_one_byte_addr) else $error("byte buffer address");

    property p_two_byte_addr;
        @(posedge clock) disable iff (reset)
        (state == mst_pkg::MST_MOVE_RD && !to_mem && two && !byte_idx)
            |-> ram_addr[7:0] == chptr - {count[6:0], 1'b0} - 8'h01;
    endproperty
    a_two_byte_addr: assert property (p_two_byte_addr) else $error("word buffer address");

    property p_dir;
        @(posedge clock) disable iff (reset)
        periph_wr |-> !to_mem && $past(ram_rd);
    endproperty
    a_dir: assert property (p_dir) else $error("peripheral write in wrong direction");

    property p_preg;
        @(posedge clock) disable iff (reset)
        (periph_rd || periph_wr) |-> periph_addr[7:1] == preg[7:1] || periph_addr == preg + 8'h01;
    endproperty
    a_preg: assert property (p_preg) else $error("peripheral address not from pointer");

    property p_type_c;
        @(posedge clock) disable iff (reset)
        ring_en |-> mode[3:2] == 2'h3 && mode[4];
    endproperty
    a_type_c: assert property (p_type_c) else $error("ring enable outside type c");
endmodule // mst_engine

// [testbench/mst_partner.sv]
// ram and peripheral register model at the far side of the engine
`timescale 1ns/10ps
module mst_partner (
    // clock
    input wire logic clock,
    // internal ram port
    input wire logic [19:0] ram_addr,
    input wire logic ram_rd,
    input wire logic ram_wr,
    input wire logic [7:0] ram_wdata,
    output logic [7:0] ram_rdata,
    // peripheral register port
    input wire logic [7:0] periph_addr,
    input wire logic periph_rd,
    input wire logic periph_wr,
    input wire logic [7:0] periph_wdata,
    output logic [7:0] periph_rdata
);
    logic [7:0] ram [logic [19:0]];
    logic [7:0] preg [logic [7:0]];
    initial begin
        ram_rdata = 8'h00;
        periph_rdata = 8'h00;
    end
    // one cycle read latency; idle data inverts every cycle so bytes one cycle stale never match
    always @(posedge clock) begin
        if (ram_wr) begin
            ram[ram_addr] = ram_wdata;
        end
        if (periph_wr) begin
            preg[periph_addr] = periph_wdata;
        end
        if (ram_rd) begin
            ram_rdata <= ram.exists(ram_addr) ? ram[ram_addr] : 8'h5a;
        end else begin
            ram_rdata <= ~ram_rdata;
        end
        if (periph_rd) begin
            periph_rdata <= preg.exists(periph_addr) ? preg[periph_addr] : 8'ha5;
        end else begin
            periph_rdata <= ~periph_rdata;
        end
    end
endmodule // mst_partner

// [testbench/mst_engine_test.sv]
// register, service and decode tests of the transfer engine
`timescale 1ns/10ps
`include "mst_regs.svh"
module mst_engine_test;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, service_req = 1'b0, service_ack, end_irq_req, vectored_next;
    logic [19:0] ram_addr;
    logic ram_rd, ram_wr, periph_rd, periph_wr, type_c_sel, timer_size_two, auto_add_en;
    logic [7:0] ram_wdata, ram_rdata, periph_addr, periph_wdata, periph_rdata, rd;
    logic ring_en, irq;
    logic [1:0] ptr_update;
    int fail_count = 0;
    int num_checks = 0;
    int ends = 0;
    always #2 clock = ~clock;
    mst_engine mst_engine_inst (.clock(clock), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .service_req(service_req),
        .service_ack(service_ack), .end_irq_req(end_irq_req), .vectored_next(vectored_next),
        .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata), .periph_addr(periph_addr), .periph_rd(periph_rd),
        .periph_wr(periph_wr), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata),
        .type_c_sel(type_c_sel), .timer_size_two(timer_size_two), .auto_add_en(auto_add_en),
        .ring_en(ring_en), .ptr_update(ptr_update), .irq(irq));
    mst_partner mst_partner_inst (.clock(clock), .ram_addr(ram_addr), .ram_rd(ram_rd),
        .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
        .periph_addr(periph_addr), .periph_rd(periph_rd), .periph_wr(periph_wr),
        .periph_wdata(periph_wdata), .periph_rdata(periph_rdata));
    // counts end-of-count pulses where they are settled
    always @(negedge clock) begin
        if (end_irq_req === 1'b1) begin
            ends++;
        end
    end
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // avalon access held until waitrequest is seen low
    task automatic avs(input logic w, input logic [3:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= 4'hf;
        avs_write <= w;
        avs_read <= ~w;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    // one service request, held through the ack cycle and dropped on the edge that ends it
    task automatic svc();
        int n;
        n = 0;
        service_req <= 1'b1;
        @(negedge clock);
        while (service_ack !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        if (n == 50) begin
            chk(8'h00, 8'h01);
        end
        @(posedge clock);
        service_req <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    // channel: count at pointer, register pointer below, mode byte just above
    task automatic chan(input logic hi, input logic [7:0] cp, md, cnt, pr);
        logic [19:0] b;
        b = hi ? `MST_HIGH_MAP_BASE : `MST_LOW_MAP_BASE;
        avs(1'b1, `MST_OFS_CTRL, {7'h0, hi});
        avs(1'b1, `MST_OFS_CHPTR, cp);
        mst_partner_inst.ram[b | (cp + 8'h01)] = md;
        mst_partner_inst.ram[b | cp] = cnt;
        mst_partner_inst.ram[b | (cp - 8'h01)] = pr;
    endtask
    initial begin
        #80000;
        chk(8'h00, 8'h01);
        finish_test();
    end
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        avs(1'b0, `MST_OFS_CTRL, 8'h00);
        chk(rd, `MST_RESET_CTRL);
        avs(1'b0, `MST_OFS_MASK, 8'h00);
        chk(rd, `MST_RESET_MASK);
        avs(1'b0, 4'hf, 8'h00);
        chk(rd, 8'h00);
        $display("test reset done");
        chan(1'b0, 8'h40, 8'h00, 8'h02, 8'h10);
        mst_partner_inst.ram[20'h0fe3d] = 8'hc3;
        svc();
        chk(mst_partner_inst.preg[8'h10], 8'hc3);
        chk(mst_partner_inst.ram[20'h0fe40], 8'h01);
        chk(ends[7:0], 8'h00);
        avs(1'b1, `MST_OFS_MASK, 8'h02);
        mst_partner_inst.ram[20'h0fe3e] = 8'h77;
        svc();
        chk(mst_partner_inst.preg[8'h10], 8'h77);
        chk(mst_partner_inst.ram[20'h0fe40], 8'h00);
        chk(ends[7:0], 8'h01);
        chk({7'h0, irq}, 8'h01);
        avs(1'b1, `MST_OFS_STATUS, 8'h02);
        chk({7'h0, irq}, 8'h00);
        $display("test one byte done");
        chan(1'b1, 8'h80, 8'h50, 8'h03, 8'h20);
        mst_partner_inst.preg[8'h20] = 8'h34;
        mst_partner_inst.preg[8'h21] = 8'h12;
        svc();
        chk(mst_partner_inst.ram[20'hffe79], 8'h34);
        chk(mst_partner_inst.ram[20'hffe78], 8'h12);
        chk(mst_partner_inst.ram[20'hffe80], 8'h02);
        $display("test two byte done");
        chan(1'b1, 8'h80, 8'h80, 8'h01, 8'h30);
        mst_partner_inst.ram[20'hffe7e] = 8'h9c;
        svc();
        chk(mst_partner_inst.preg[8'h30], 8'h9c);
        chk(ends[7:0], 8'h01);
        chk({7'h0, vectored_next}, 8'h01);
        svc();
        chk({7'h0, vectored_next}, 8'h00);
        chk(mst_partner_inst.ram[20'hffe80], 8'h00);
        $display("test vectored done");
        for (int k = 0; k < 4; k++) begin
            chan(1'b0, 8'hc0, {1'b0, k[1], k[0], k[1], 2'b11, k[1:0]}, 8'h01, 8'h40);
            svc();
            chk({7'h0, type_c_sel}, 8'h01);
            chk({6'h0, ptr_update}, {6'h0, k[1:0]});
            chk({5'h0, timer_size_two, auto_add_en, ring_en}, {5'h0, k[1], k[0], k[1]});
            avs(1'b0, `MST_OFS_MODE, 8'h00);
            chk(rd, {1'b0, k[1], k[0], k[1], 2'b11, k[1:0]});
        end
        $display("test type c done");
        finish_test();
    end
endmodule // mst_engine_test
